// [common/trns_pkg.sv]
// Package with register map, field positions and timing constants of the random source.
package trns_pkg;
   localparam logic [11:0] REG_ENABLE_OFS = 12'h060;
   localparam logic [11:0] REG_CONFIG_OFS = 12'h064;
   localparam logic [11:0] REG_POP_OFS = 12'h068;
   localparam logic [11:0] REG_STATE_OFS = 12'h06C;
   localparam logic [11:0] REG_LOCAL_BASE_OFS = 12'h078;
   localparam int ENABLE_BIT = 0;
   localparam int RATE_LSB = 0;
   localparam int RATE_WIDTH = 4;
   localparam int IRQ_EN_BIT = 8;
   localparam int READY_BIT = 0;
   localparam int EMPTY_READ_BIT = 1;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [31:0] LOCAL_BASE_RESET = 32'h1000_0000;
   localparam logic [31:0] MIX_SEED = 32'h6A09_E667;
   localparam int FIFO_DEPTH = 4;
   localparam int SKID_DEPTH = 2;
   localparam int READY_LEVEL = 2;
   localparam real CLOCK_MHZ = 10.0;
   localparam real RATED_CLOCK_MHZ = 90.0;
   localparam real RATED_MBPS = 2.8;
   localparam int WORD_BITS = 32;
   localparam int BASE_PERIOD = int'(RATED_CLOCK_MHZ * WORD_BITS / RATED_MBPS) / 32 * 32;
   localparam int PERIOD_WIDTH = 26;

   typedef enum logic [2:0] {
      TRNS_SEL_NONE,
      TRNS_SEL_ENABLE,
      TRNS_SEL_CONFIG,
      TRNS_SEL_POP,
      TRNS_SEL_STATE,
      TRNS_SEL_BASE
   } trns_sel_t;

   typedef struct packed {
      logic take;
      logic write;
      trns_sel_t sel;
      logic [31:0] wdata;
   } trns_acc_t;
endpackage

// [design/true_random_number_source.sv]
// Hardware random word source with its register file, mixer and output FIFO.
`timescale 1ns/1ps
module true_random_number_source (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic oscA,
   input wire logic oscB,
   input wire logic protectN,
   input wire logic pciReq,
   input wire logic pciWe,
   input wire logic [11:0] pciAddr,
   input wire logic [31:0] pciWdata,
   output logic pciAck,
   output logic [31:0] pciRdata,
   input wire logic cpuReq,
   input wire logic cpuWe,
   input wire logic [31:0] cpuAddr,
   input wire logic [31:0] cpuWdata,
   output logic cpuAck,
   output logic [31:0] cpuRdata,
   output logic randomReadyIrq
);
   localparam int PERIOD_WIDTH_L = trns_pkg::PERIOD_WIDTH;
   logic [1:0] oscASync_reg;
   logic [1:0] oscBSync_reg;
   logic [1:0] protSync_reg;
   logic [31:0] enable_reg;
   logic [31:0] config_reg;
   logic [31:0] localBase_reg;
   logic emptyRead_reg;
   logic [31:0] mix_reg;
   logic [31:0] mix_next;
   logic [PERIOD_WIDTH_L-1:0] period_reg;
   logic [31:0] skidMem_reg [trns_pkg::SKID_DEPTH];
   logic skidHead_reg;
   logic [1:0] skidCount_reg;
   logic [31:0] fifoMem_reg [trns_pkg::FIFO_DEPTH];
   logic [1:0] fifoWr_reg;
   logic [1:0] fifoRd_reg;
   logic [2:0] fifoCount_reg;
   logic rawBit;
   logic protectedMode;
   logic generatorOn;
   logic [PERIOD_WIDTH_L-1:0] periodTarget;
   logic genValid;
   logic skidReady;
   logic skidValid;
   logic fifoReady;
   logic skidToFifo;
   logic popTake;
   logic randomReady;
   logic [31:0] stateWord;
   trns_pkg::trns_acc_t cpuAcc;
   trns_pkg::trns_acc_t pciAcc;
   trns_pkg::trns_acc_t acc;

   function automatic trns_pkg::trns_sel_t decodeOfs(input logic [11:0] ofs);
      case (ofs)
         trns_pkg::REG_ENABLE_OFS: decodeOfs = trns_pkg::TRNS_SEL_ENABLE;
         trns_pkg::REG_CONFIG_OFS: decodeOfs = trns_pkg::TRNS_SEL_CONFIG;
         trns_pkg::REG_POP_OFS: decodeOfs = trns_pkg::TRNS_SEL_POP;
         trns_pkg::REG_STATE_OFS: decodeOfs = trns_pkg::TRNS_SEL_STATE;
         trns_pkg::REG_LOCAL_BASE_OFS: decodeOfs = trns_pkg::TRNS_SEL_BASE;
         default: decodeOfs = trns_pkg::TRNS_SEL_NONE;
      endcase
   endfunction

   // The oscA, oscB and protectN pin inputs pass two flip-flops before any logic reads them; the bus inputs are used directly.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         oscASync_reg <= 2'h0;
      end else begin
         oscASync_reg <= {oscASync_reg[0], oscA};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         oscBSync_reg <= 2'h0;
      end else begin
         oscBSync_reg <= {oscBSync_reg[0], oscB};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         protSync_reg <= 2'h3;
      end else begin
         protSync_reg <= {protSync_reg[0], protectN};
      end
   end

   assign rawBit = oscASync_reg[1] ^ oscBSync_reg[1];
   assign protectedMode = ~protSync_reg[1];
   assign generatorOn = enable_reg[trns_pkg::ENABLE_BIT];

   // The local processor always wins; a PCI request waits while the processor asks.
   always_comb begin
      cpuAcc.take = cpuReq & ~cpuAck & (cpuAddr[31:12] == localBase_reg[31:12]);
      cpuAcc.write = cpuWe;
      cpuAcc.sel = decodeOfs(cpuAddr[11:0]);
      cpuAcc.wdata = cpuWdata;
      pciAcc.take = pciReq & ~pciAck & ~cpuReq & ~protectedMode;
      pciAcc.write = pciWe;
      pciAcc.sel = decodeOfs(pciAddr);
      pciAcc.wdata = pciWdata;
      acc = cpuAcc.take ? cpuAcc : pciAcc;
   end

   assign popTake = acc.take & ~acc.write & (acc.sel == trns_pkg::TRNS_SEL_POP);

   // Control registers written by software.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         enable_reg <= trns_pkg::ENABLE_RESET;
      end else if (acc.take && acc.write && acc.sel == trns_pkg::TRNS_SEL_ENABLE) begin
         enable_reg <= acc.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         config_reg <= trns_pkg::CONFIG_RESET;
      end else if (acc.take && acc.write && acc.sel == trns_pkg::TRNS_SEL_CONFIG) begin
         config_reg <= acc.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         localBase_reg <= trns_pkg::LOCAL_BASE_RESET;
      end else if (acc.take && acc.write && acc.sel == trns_pkg::TRNS_SEL_BASE) begin
         localBase_reg <= acc.wdata;
      end
   end

   // Sticky underflow flag; a new empty read beats a clear in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         emptyRead_reg <= 1'b0;
      end else if (popTake && fifoCount_reg == 3'h0) begin
         emptyRead_reg <= 1'b1;
      end else if (acc.take && acc.write && acc.sel == trns_pkg::TRNS_SEL_STATE
                   && acc.wdata[trns_pkg::EMPTY_READ_BIT]) begin
         emptyRead_reg <= 1'b0;
      end
   end

   // Entropy is folded into the state every cycle while the generator is enabled, with a nonlinear feedback term.
   always_comb begin
      mix_next = {mix_reg[30:0], mix_reg[31] ^ mix_reg[21] ^ mix_reg[1] ^ mix_reg[0] ^ rawBit};
      mix_next[7:0] = mix_next[7:0] ^ (mix_reg[15:8] & mix_reg[23:16]) ^ mix_reg[31:24];
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mix_reg <= trns_pkg::MIX_SEED;
      end else if (generatorOn) begin
         mix_reg <= mix_next;
      end
   end

   assign stateWord = mix_reg ^ {mix_reg[18:0], mix_reg[31:19]} ^ {mix_reg[5:0], mix_reg[31:6]};

   // Word period is the base period shifted left by the configured rate field.
   assign periodTarget = (PERIOD_WIDTH_L'(trns_pkg::BASE_PERIOD)
      << config_reg[trns_pkg::RATE_LSB +: trns_pkg::RATE_WIDTH])
      - PERIOD_WIDTH_L'(1);
   assign genValid = generatorOn && (period_reg >= periodTarget);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         period_reg <= '0;
      end else if (!generatorOn) begin
         period_reg <= '0;
      end else if (genValid) begin
         if (skidReady) begin
            period_reg <= '0;
         end
      end else begin
         period_reg <= period_reg + PERIOD_WIDTH_L'(1);
      end
   end

   // Two-entry buffer between the mixer and the FIFO; the period counter holds when it fills.
   assign skidReady = (skidCount_reg != 2'(trns_pkg::SKID_DEPTH));
   assign skidValid = (skidCount_reg != 2'h0);
   assign fifoReady = (fifoCount_reg != 3'(trns_pkg::FIFO_DEPTH));
   assign skidToFifo = skidValid & fifoReady;

   always_ff @(posedge sys_clk) begin
      if (genValid && skidReady) begin
         skidMem_reg[skidHead_reg ^ skidCount_reg[0]] <= stateWord;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         skidHead_reg <= 1'b0;
      end else if (skidToFifo) begin
         skidHead_reg <= ~skidHead_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         skidCount_reg <= 2'h0;
      end else begin
         skidCount_reg <= skidCount_reg + 2'(genValid && skidReady) - 2'(skidToFifo);
      end
   end

   // Four-entry output FIFO.
   always_ff @(posedge sys_clk) begin
      if (skidToFifo) begin
         fifoMem_reg[fifoWr_reg] <= skidMem_reg[skidHead_reg];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fifoWr_reg <= 2'h0;
      end else if (skidToFifo) begin
         fifoWr_reg <= fifoWr_reg + 2'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fifoRd_reg <= 2'h0;
      end else if (popTake && fifoCount_reg != 3'h0) begin
         fifoRd_reg <= fifoRd_reg + 2'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fifoCount_reg <= 3'h0;
      end else begin
         fifoCount_reg <= fifoCount_reg + 3'(skidToFifo)
            - 3'(popTake && fifoCount_reg != 3'h0);
      end
   end

   assign randomReady = (fifoCount_reg >= 3'(trns_pkg::READY_LEVEL));

   // Read data one cycle after a request is taken; acknowledge pulses one cycle after any request, taken or not, a PCI request only while cpuReq is low.
   function automatic logic [31:0] readValue(input trns_pkg::trns_sel_t sel);
      case (sel)
         trns_pkg::TRNS_SEL_ENABLE: readValue = enable_reg;
         trns_pkg::TRNS_SEL_CONFIG: readValue = config_reg;
         trns_pkg::TRNS_SEL_POP: readValue = (fifoCount_reg != 3'h0) ?
            fifoMem_reg[fifoRd_reg] : 32'h0000_0000;
         trns_pkg::TRNS_SEL_STATE: readValue = {30'h0, emptyRead_reg, randomReady};
         trns_pkg::TRNS_SEL_BASE: readValue = localBase_reg;
         default: readValue = 32'h0000_0000;
      endcase
   endfunction

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpuAck <= 1'b0;
         cpuRdata <= 32'h0000_0000;
      end else begin
         cpuAck <= cpuReq & ~cpuAck;
         if (cpuAcc.take && !cpuWe) begin
            cpuRdata <= readValue(cpuAcc.sel);
         end else begin
            cpuRdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pciAck <= 1'b0;
         pciRdata <= 32'h0000_0000;
      end else begin
         pciAck <= pciReq & ~pciAck & ~cpuReq;
         if (pciAcc.take && !pciWe) begin
            pciRdata <= readValue(pciAcc.sel);
         end else begin
            pciRdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         randomReadyIrq <= 1'b0;
      end else begin
         randomReadyIrq <= randomReady & config_reg[trns_pkg::IRQ_EN_BIT];
      end
   end
endmodule

// [dv/trns_checker.sv]
// Port assertions for the random word source.
`timescale 1ns/1ps
module trns_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic protectN,
   input wire logic pciReq,
   input wire logic pciWe,
   input wire logic [11:0] pciAddr,
   input wire logic pciAck,
   input wire logic [31:0] pciRdata,
   input wire logic cpuReq,
   input wire logic cpuAck,
   input wire logic randomReadyIrq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic pciTake;
   logic pciMap;
   assign pciTake = pciReq && !pciAck && !cpuReq && !pciWe;
   assign pciMap = pciAddr inside {12'h060, 12'h064, 12'h068, 12'h06C, 12'h078};
   a_cpu_ack_time: assert property (cpuReq && !cpuAck |=> cpuAck)
      else $error("CPU ack late.");
   a_cpu_ack_pulse: assert property (cpuAck |=> !cpuAck)
      else $error("CPU ack too long.");
   a_pci_ack_time: assert property (pciReq && !pciAck && !cpuReq |=> pciAck)
      else $error("PCI ack late.");
   a_pci_idle_zero: assert property (!pciAck |-> pciRdata == 32'h0000_0000)
      else $error("PCI data without ack.");
   a_protect_blocks: assert property (!protectN [*4] ##0 pciTake |=> pciRdata == 32'h0)
      else $error("Protected PCI read returned data.");
   a_unmapped_zero: assert property (pciTake && !pciMap |=> pciRdata == 32'h0)
      else $error("Unmapped PCI read returned data.");
   a_reset_quiet: assert property ($fell(rst) |-> !cpuAck && !pciAck && !randomReadyIrq)
      else $error("Outputs active after reset.");
   a_irq_ready: assert property (pciAck && !pciWe && pciAddr == 12'h06C
      && randomReadyIrq && $past(protectN, 3) |-> pciRdata[0])
      else $error("Interrupt without ready flag.");
   c_irq: cover property ($rose(randomReadyIrq));
   c_protect: cover property (!protectN && pciAck);
   c_cpu: cover property (cpuAck);
endmodule

// [dv/trns_osc_model.sv]
// Model of two free-running oscillators that drift against the system clock.
`timescale 1ns/1ps
module trns_osc_model (
   output logic oscA,
   output logic oscB
);
   initial begin
      oscA = 1'b0;
      forever #37.3 oscA = ~oscA;
   end
   initial begin
      oscB = 1'b1;
      forever #53.9 oscB = ~oscB;
   end
endmodule

// [dv/true_random_number_source_tb.sv]
// Self-checking testbench for the random word source.
`timescale 1ns/1ps
module true_random_number_source_tb;
   localparam logic [31:0] B = trns_pkg::LOCAL_BASE_RESET;
   localparam logic [31:0] EN = B + 32'h0000_0060;
   localparam logic [31:0] CF = B + 32'h0000_0064;
   localparam logic [31:0] DT = B + 32'h0000_0068;
   localparam logic [31:0] ST = B + 32'h0000_006C;
   localparam logic [31:0] BS = B + 32'h0000_0078;
   logic sys_clk, rst, oscA, oscB, protectN, pciReq, pciWe, pciAck;
   logic cpuReq, cpuWe, cpuAck, randomReadyIrq;
   logic [11:0] pciAddr;
   logic [31:0] pciWdata, pciRdata, cpuAddr, cpuWdata, cpuRdata, q;
   int errorCnt = 0;
   int checkCount = 0;
   int cycleCnt = 0;
   int enCycle = 0;
   always @(posedge sys_clk) begin
      cycleCnt <= cycleCnt + 1;
   end
   true_random_number_source i_true_random_number_source (.sys_clk, .rst, .oscA, .oscB,
      .protectN, .pciReq, .pciWe, .pciAddr, .pciWdata, .pciAck, .pciRdata, .cpuReq, .cpuWe,
      .cpuAddr, .cpuWdata, .cpuAck, .cpuRdata, .randomReadyIrq);
   trns_osc_model i_trns_osc_model (.oscA, .oscB);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask
   task chkGap(input string n, input int words);
      int lo;
      lo = words * trns_pkg::BASE_PERIOD;
      chk(n, (cycleCnt - enCycle) >= lo && (cycleCnt - enCycle) <= lo + 8, 1'b1);
   endtask
   task reportAndStop;
      $display("checks %0d errors %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task acc(input bit cpu, input logic we, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      if (cpu) begin
         cpuReq <= 1'b1; cpuWe <= we; cpuAddr <= a; cpuWdata <= d;
      end else begin
         pciReq <= 1'b1; pciWe <= we; pciAddr <= a[11:0]; pciWdata <= d;
      end
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((cpu ? cpuAck : pciAck) !== 1'b1 && n < 20);
      q = cpu ? cpuRdata : pciRdata;
      cpuReq <= 1'b0;
      pciReq <= 1'b0;
      chk("ack", n < 20, 1'b1);
   endtask
   task testReset;
      acc(1, 0, EN, 0); chk("enable", q, trns_pkg::ENABLE_RESET);
      acc(1, 0, CF, 0); chk("config", q, trns_pkg::CONFIG_RESET);
      acc(1, 0, BS, 0); chk("base", q, B);
      acc(1, 0, ST, 0); chk("status", q, 32'h0000_0000);
   endtask
   task testProtect;
      @(posedge sys_clk);
      protectN <= 1'b0;
      repeat (4) @(posedge sys_clk);
      acc(0, 1, EN, 1);
      acc(0, 0, BS, 0); chk("pci locked", q, 32'h0000_0000);
      acc(1, 0, EN, 0); chk("pci write dropped", q, 32'h0000_0000);
      protectN <= 1'b1;
      repeat (4) @(posedge sys_clk);
      acc(0, 0, BS, 0); chk("pci open", q, B);
      acc(0, 0, 32'h0000_0070, 0); chk("unmapped", q, 32'h0000_0000);
   endtask
   task testEmpty;
      acc(1, 1, EN, 1);
      enCycle = cycleCnt;
      acc(1, 0, DT, 0); chk("empty read", q, 32'h0000_0000);
      acc(1, 0, ST, 0); chk("underflow", q[1], 1'b1);
      acc(1, 0, ST, 0); chk("underflow kept", q[1], 1'b1);
      acc(1, 1, ST, 32'h0000_0002);
      acc(1, 0, ST, 0); chk("underflow clear", q[1], 1'b0);
   endtask
   task testReady;
      int n;
      acc(1, 1, CF, 32'h0000_0100);
      n = 0;
      do begin
         acc(0, 0, ST, 0);
         n++;
      end while (q[0] !== 1'b1 && n < 1500);
      chkGap("rate", 2);
      chk("ready", q[0], 1'b1);
      chk("irq", randomReadyIrq, 1'b1);
      acc(1, 0, DT, 0);
      acc(1, 0, ST, 0); chk("ready gone", q[0], 1'b0);
      chk("irq gone", randomReadyIrq, 1'b0);
   endtask
   task testFull;
      repeat (8500) @(posedge sys_clk);
      for (int i = 0; i < 4; i++) acc(1, 0, DT, 0);
      acc(1, 0, ST, 0); chk("no word lost", q[0], 1'b1);
   endtask
   task testRate;
      int n;
      for (int i = 0; i < 3; i++) acc(1, 0, DT, 0);
      acc(1, 0, ST, 0);
      chk("drained", q[1:0], 32'h0000_0000);
      acc(1, 1, EN, 0);
      acc(1, 1, CF, 32'h0000_0001);
      acc(1, 1, EN, 1);
      enCycle = cycleCnt;
      n = 0;
      do begin
         acc(1, 0, ST, 0);
         n++;
      end while (q[0] !== 1'b1 && n < 2000);
      chkGap("rate shift", 4);
      chk("irq masked", randomReadyIrq, 1'b0);
   endtask
   task testBase;
      acc(1, 1, BS, 32'h2000_0000);
      acc(1, 0, 32'h2000_0060, 0); chk("new base", q, 32'h0000_0001);
      acc(1, 0, EN, 0); chk("old base", q, 32'h0000_0000);
   endtask
   initial begin
      rst = 1'b1; protectN = 1'b1; pciReq = 1'b0; pciWe = 1'b0; pciAddr = 12'h000;
      pciWdata = 32'h0; cpuReq = 1'b0; cpuWe = 1'b0; cpuAddr = 32'h0; cpuWdata = 32'h0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      testReset();
      testProtect();
      testEmpty();
      testReady();
      testFull();
      testRate();
      testBase();
      reportAndStop();
   end
   initial begin
      #3000000;
      errorCnt++;
      reportAndStop();
   end
endmodule
bind true_random_number_source trns_checker i_trns_checker (.sys_clk, .rst, .protectN,
   .pciReq, .pciWe, .pciAddr, .pciAck, .pciRdata, .cpuReq, .cpuAck, .randomReadyIrq);
